// ==== bench/exec_model.sv ====
// instruction executor stand-in answering go with done
`timescale 1ns/1ps
module exec_model #(
  parameter int ENGINES = 3
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // engine side
  input  wire logic [ENGINES-1:0] go_i,
  input  wire logic [ENGINES-1:0] abort_i,
  input  wire logic [3:0]         lat_i,
  output logic      [ENGINES-1:0] done_o
);
  // ****************
  // latency counters
  // ****************
  logic [3:0]         cnt [ENGINES];
  logic [ENGINES-1:0] act;

  // abort drops the instruction, so no stray done follows
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act    <= '0;
      done_o <= '0;
      for (int k = 0; k < ENGINES; k++) cnt[k] <= '0;
    end else begin
      for (int k = 0; k < ENGINES; k++) begin
        done_o[k] <= 1'b0;
        if (abort_i[k]) act[k] <= 1'b0;
        else if (go_i[k]) begin
          act[k] <= 1'b1;
          cnt[k] <= lat_i;
        end else if (act[k] && cnt[k] == 4'h0) begin
          act[k]    <= 1'b0;
          done_o[k] <= 1'b1;
        end else if (act[k]) cnt[k] <= cnt[k] - 4'h1;
      end
    end
  end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the engine run control block
`timescale 1ns/1ps
module testbench;
  import engine_run_pkg::*;
  // ***********
  // environment
  // ***********
  localparam int              SC  = 4;
  localparam logic [PC_W-1:0] LIM = 7'h03;
  logic        clk_i;
  logic        rst_n_i;
  logic        wr_en_i;
  logic        rd_en_i;
  logic [7:0]  addr_i;
  logic [7:0]  wdata_i;
  logic [7:0]  rdata_o;
  logic        prog_wr_req_i;
  logic [1:0]  prog_eng_i;
  logic        prog_wr_ok_o;
  logic [2:0]  exec_done_i;
  logic [2:0]  exec_go_o;
  logic [2:0]  exec_abort_o;
  logic [20:0] exec_pc_o;
  logic        normal_o;
  logic        pwm_freeze_o;
  logic [3:0]  lat;
  int          n_mismatch;
  int          comparisons;
  int          cycles;
  int          n_go [3];
  int          n_ab [3];
  int          b;

  engine_run_control #(.ENGINES(3), .PC_LIMIT(LIM), .START_CYC(SC)) engine_run_control_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .prog_wr_req_i(prog_wr_req_i), .prog_eng_i(prog_eng_i), .prog_wr_ok_o(prog_wr_ok_o),
    .exec_done_i(exec_done_i), .exec_go_o(exec_go_o), .exec_abort_o(exec_abort_o),
    .exec_pc_o(exec_pc_o), .normal_o(normal_o), .pwm_freeze_o(pwm_freeze_o));

  exec_model #(.ENGINES(3)) exec_model_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(exec_go_o), .abort_i(exec_abort_o),
    .lat_i(lat), .done_o(exec_done_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // counted on the falling edge, away from the launching edge
  always @(negedge clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (exec_go_o[k] === 1'b1) n_go[k]++;
      if (exec_abort_o[k] === 1'b1) n_ab[k]++;
    end
  end

  // hang guard, several times the expected run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ************
  // shared tasks
  // ************
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i  <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e, "register read");
  endtask

  // polls until the value shows, bounded
  task automatic wait_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(a, d);
      if (d === e) break;
    end
    chk(d, e, "polled read");
  endtask

  task automatic wait_n(input int k, input int base, input bit ab);
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if ((ab ? n_ab[k] : n_go[k]) > base) break;
    end
    chk(8'(i < 40), 8'h01, "pulse seen");
  endtask

  function automatic logic [7:0] pc_of(input int k);
    return {1'b0, exec_pc_o[7*k +: 7]};
  endfunction

  task automatic gate(input logic [1:0] k, input logic e);
    @(posedge clk_i);
    prog_wr_req_i <= 1'b1;
    prog_eng_i    <= k;
    #1 chk(8'(prog_wr_ok_o), 8'(e), "program gate");
  endtask

  // *********
  // scenarios
  // *********
  task automatic t_standby();
    rdchk(8'h00, 8'h00);
    rdchk(8'h10, 8'h00);
    wr(8'h00, 8'h3f);
    rdchk(8'h00, 8'h00);
    wr(8'h37, 8'h05);
    chk(pc_of(0), 8'h00, "standby pc");
    rdchk(8'h37, 8'h00);
    wr(8'h01, 8'h2a);
    rdchk(8'h01, 8'h2a);
    wr(8'h01, 8'h00);
    $display("standby done");
  endtask

  task automatic t_startup();
    wr(8'h00, 8'h40);
    #1 chk(8'(normal_o), 8'h00, "early normal");
    repeat (SC - 1) @(posedge clk_i);
    #1 chk(8'(normal_o), 8'h00, "still starting");
    @(posedge clk_i);
    #1 chk(8'(normal_o), 8'h01, "normal mode");
    rdchk(8'h00, 8'h40);
    $display("startup done");
  endtask

  task automatic t_pc_hold();
    wr(8'h37, 8'h12);
    wr(8'h38, 8'h21);
    wr(8'h39, 8'h33);
    rdchk(8'h38, 8'h21);
    chk(pc_of(0), 8'h12, "pc0");
    chk(pc_of(2), 8'h33, "pc2");
    b = n_go[0];
    wr(8'h00, 8'h50);
    repeat (10) @(negedge clk_i);
    chk(8'(n_go[0] - b), 8'h00, "no issue");
    rdchk(8'h37, 8'h00);
    wr(8'h37, 8'h7f);
    chk(pc_of(0), 8'h12, "pc locked");
    wr(8'h00, 8'h40);
    $display("pc hold done");
  endtask

  task automatic t_styles();
    lat <= 4'h2;
    wr(8'h01, 8'h20);
    wr(8'h37, 8'(LIM));
    b = n_go[0];
    wr(8'h00, 8'h50);
    wait_rd(8'h00, 8'h40);
    chk(8'(n_go[0] - b), 8'h01, "step issues");
    chk(pc_of(0), 8'h00, "step wrap");
    wr(8'h37, 8'h01);
    wr(8'h00, 8'h70);
    wait_rd(8'h00, 8'h40);
    chk(8'(n_go[0] - b), 8'h02, "once issues");
    chk(pc_of(0), 8'h01, "once keeps pc");
    lat <= 4'h0;
    b = n_go[0];
    wr(8'h00, 8'h60);
    repeat (40) @(negedge clk_i);
    chk(8'(n_go[0] - b > 4), 8'h01, "free runs");
    wr(8'h00, 8'h40);
    repeat (10) @(negedge clk_i);
    chk(pc_of(0), 8'((n_go[0] - b + 1) % 4), "free pc");
    rdchk(8'h00, 8'h40);
    wr(8'h01, 8'h00);
    $display("styles done");
  endtask

  task automatic t_halt();
    lat <= 4'ha;
    wr(8'h38, 8'h05);
    wr(8'h01, 8'h08);
    b = n_go[1];
    wr(8'h00, 8'h48);
    wait_n(1, b, 1'b0);
    rdchk(8'h3a, 8'h02);
    b = n_ab[1];
    wr(8'h01, 8'h0c);
    wait_n(1, b, 1'b1);
    b = n_go[1];
    repeat (20) @(negedge clk_i);
    chk(pc_of(1), 8'h05, "halt keeps pc");
    chk(8'(n_go[1] - b), 8'h00, "halt idle");
    rdchk(8'h3a, 8'h00);
    wr(8'h00, 8'h40);
    wr(8'h01, 8'h00);
    $display("halt done");
  endtask

  task automatic t_load();
    lat <= 4'h1;
    wr(8'h39, 8'h11);
    gate(2'h2, 1'b0);
    wr(8'h01, 8'h01);
    repeat (2) @(posedge clk_i);
    #1 chk(pc_of(2), 8'h00, "load clears pc");
    chk(8'(pwm_freeze_o), 8'h01, "freeze");
    rdchk(8'h3a, 8'h00);
    gate(2'h2, 1'b1);
    gate(2'h0, 1'b0);
    gate(2'h3, 1'b0);
    prog_wr_req_i <= 1'b0;
    wr(8'h01, 8'h21);
    b = n_go[0];
    wr(8'h00, 8'h60);
    repeat (15) @(negedge clk_i);
    chk(8'(n_go[0] - b), 8'h00, "engines held");
    wr(8'h01, 8'h20);
    wait_n(0, b, 1'b0);
    chk(8'(pwm_freeze_o), 8'h00, "unfreeze");
    wr(8'h00, 8'h00);
    #1 chk(8'(normal_o), 8'h00, "standby drop");
    wr(8'h01, 8'h00);
    $display("load done");
  endtask

  task final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    rst_n_i       = 1'b0;
    wr_en_i       = 1'b0;
    rd_en_i       = 1'b0;
    addr_i        = 8'h00;
    wdata_i       = 8'h00;
    prog_wr_req_i = 1'b0;
    prog_eng_i    = 2'h0;
    lat           = 4'h2;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_standby();
    t_startup();
    t_pc_hold();
    t_styles();
    t_halt();
    t_load();
    final_report();
  end
endmodule

// ==== hdl/engine_if.sv ====
// per-engine carrier between control registers and sequencer
`timescale 1ns/1ps
interface engine_if;
  import engine_run_pkg::*;

  style_e              style;
  state_e              state;
  logic                run_ok;
  logic                load_entry;
  logic                pc_wr;
  logic [PC_W-1:0]     pc_wdata;
  logic                done;
  logic                go;
  logic                abort;
  logic                busy;
  logic                clr;
  logic [PC_W-1:0]     pc;

  modport ctl (output style, state, run_ok, load_entry, pc_wr, pc_wdata, done,
               input  go, abort, busy, clr, pc);
  modport eng (input  style, state, run_ok, load_entry, pc_wr, pc_wdata, done,
               output go, abort, busy, clr, pc);
endinterface

// ==== hdl/engine_run_control.sv ====
// control registers and run state of three execution engines
`timescale 1ns/1ps
module engine_run_control
  import engine_run_pkg::*;
#(
  parameter int              ENGINES    = 3,
  parameter logic [PC_W-1:0] PC_LIMIT   = PC_LIMIT_DEF,
  parameter int              START_CYC  = STARTUP_CYC
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // register access from serial interface
  input  wire logic                    wr_en_i,
  input  wire logic                    rd_en_i,
  input  wire logic [7:0]              addr_i,
  input  wire logic [7:0]              wdata_i,
  output logic [7:0]                   rdata_o,
  // program memory write gate
  input  wire logic                    prog_wr_req_i,
  input  wire logic [1:0]              prog_eng_i,
  output logic                         prog_wr_ok_o,
  // instruction executor
  input  wire logic [ENGINES-1:0]      exec_done_i,
  output logic [ENGINES-1:0]           exec_go_o,
  output logic [ENGINES-1:0]           exec_abort_o,
  output logic [ENGINES*PC_W-1:0]      exec_pc_o,
  // chip status
  output logic                         normal_o,
  output logic                         pwm_freeze_o
);

  localparam int SU_CYC = START_CYC;

  logic [7:0]         style_reg;
  logic [7:0]         next_style_reg;
  logic [7:0]         state_reg;
  logic [7:0]         next_state_reg;
  logic [CNT_W-1:0]   su_cnt;
  logic [CNT_W-1:0]   next_su_cnt;
  logic               normal;
  logic               next_normal;
  logic [7:0]         rdata;
  logic [7:0]         next_rdata;
  logic               chip_en;
  logic               load_any;
  logic [ENGINES-1:0] busy;
  logic [ENGINES-1:0] clr;
  logic [ENGINES-1:0] in_load;
  logic [ENGINES-1:0] hold_style;
  logic [ENGINES-1:0] load_entry;
  logic [ENGINES-1:0] pc_wr;
  logic               wr_style;
  logic               wr_state;

  engine_if eif[ENGINES] ();

  assign chip_en  = style_reg[CHIP_EN_BIT];
  assign wr_style = wr_en_i && addr_i == ADDR_STYLE;
  assign wr_state = wr_en_i && addr_i == ADDR_STATE;
  assign load_any = |in_load;

  // ************************************************************
  // per-engine wiring
  // ************************************************************
  genvar k;
  generate
    for (k = 0; k < ENGINES; k++) begin : g_eng
      localparam int LO = field_lo(k);
      assign eif[k].style    = style_e'(style_reg[LO+:2]);
      assign eif[k].state    = state_e'(state_reg[LO+:2]);
      assign eif[k].run_ok   = normal && !load_any;
      assign eif[k].done     = exec_done_i[k];
      assign eif[k].pc_wdata = wdata_i[PC_W-1:0];
      assign in_load[k]      = (state_reg[LO+:2] == ST_LOAD);
      assign hold_style[k]   = (style_reg[LO+:2] == STYLE_HOLD);
      assign load_entry[k]   = wr_state && wdata_i[LO+:2] == ST_LOAD && !in_load[k];
      assign eif[k].load_entry = load_entry[k];
      // a busy engine refuses the write, so a done cannot race it
      // counter written only under hold
      assign pc_wr[k]        = wr_en_i && addr_i == ADDR_PC0 + 8'(k) && chip_en
                               && hold_style[k] && !eif[k].busy;
      assign eif[k].pc_wr    = pc_wr[k];
      assign busy[k]         = eif[k].busy;
      assign clr[k]          = eif[k].clr;
      assign exec_go_o[k]    = eif[k].go;
      assign exec_abort_o[k] = eif[k].abort;
      assign exec_pc_o[k*PC_W+:PC_W] = eif[k].pc;

      engine_seq #(
        .PC_LIMIT (PC_LIMIT)
      ) u_seq (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .e       (eif[k])
      );
    end
  endgenerate

  // ************************************************************
  // control registers
  // ************************************************************
  always_comb begin
    next_style_reg = style_reg;
    next_state_reg = state_reg;
    for (int i = 0; i < ENGINES; i++) begin
      if (clr[i]) begin
        next_style_reg[field_lo(i)+:2] = STYLE_HOLD;
      end
    end
    // a fresh host command outranks the self-clear
    if (wr_style) begin
      next_style_reg[CHIP_EN_BIT] = wdata_i[CHIP_EN_BIT];
      if (chip_en) begin
        next_style_reg[5:0] = wdata_i[5:0];
      end
    end
    // host may order any state, load included, from any current state
    if (wr_state) begin
      next_state_reg[5:0] = wdata_i[5:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      style_reg <= STYLE_RST;
      state_reg <= STATE_RST;
    end else begin
      style_reg <= next_style_reg;
      state_reg <= next_state_reg;
    end
  end

  // ************************************************************
  // startup sequence
  // ************************************************************
  always_comb begin
    next_su_cnt = su_cnt;
    if (!chip_en) begin
      next_su_cnt = '0;
    end else if (su_cnt != CNT_W'(SU_CYC)) begin
      next_su_cnt = su_cnt + 1'b1;
    end
    // next enable, so normal drops with the write that clears it
    next_normal = next_style_reg[CHIP_EN_BIT] && next_su_cnt == CNT_W'(SU_CYC);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      su_cnt <= '0;
      normal <= 1'b0;
    end else begin
      su_cnt <= next_su_cnt;
      normal <= next_normal;
    end
  end

  assign normal_o     = normal;
  assign pwm_freeze_o = load_any;

  // ************************************************************
  // program write gate
  // ************************************************************
  // load state and engine idle
  // host is expected to poll busy first
  always_comb begin
    prog_wr_ok_o = 1'b0;
    if (prog_wr_req_i && 32'(prog_eng_i) < ENGINES) begin
      prog_wr_ok_o = in_load[prog_eng_i] && !busy[prog_eng_i];
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    next_rdata = rdata;
    if (rd_en_i) begin
      next_rdata = 8'h00;
      if (addr_i == ADDR_STYLE) begin
        next_rdata = {1'b0, style_reg[6:0]};
      end else if (addr_i == ADDR_STATE) begin
        next_rdata = {2'b00, state_reg[5:0]};
      end else if (addr_i == ADDR_BUSY) begin
        next_rdata = 8'(busy);
      end else begin
        for (int i = 0; i < ENGINES; i++) begin
          if (addr_i == ADDR_PC0 + 8'(i) && chip_en && hold_style[i]) begin
            next_rdata = 8'(exec_pc_o[i*PC_W+:PC_W]);
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;

  // ************************************************************
  // checks
  // ************************************************************
  a_standby_style_lock: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!chip_en && wr_style && clr == '0) |=> style_reg[5:0] == $past(style_reg[5:0])
  ) else $error("style field changed in standby");

  a_startup_delay: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(chip_en) |-> !normal_o ##SU_CYC (normal_o || !chip_en || $fell(chip_en))
  ) else $error("normal mode not reached after startup");

  a_normal_needs_en: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    normal_o |-> chip_en && su_cnt == CNT_W'(SU_CYC)
  ) else $error("normal mode without finished startup");

  a_load_freeze_all: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    load_any |-> pwm_freeze_o ##1 (exec_go_o == '0)
  ) else $error("engine fetched while a load was active");

  a_load_pc_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    load_entry[0] |=> exec_pc_o[PC_W-1:0] == '0
  ) else $error("load entry did not clear the counter");

  a_prog_gate_busy: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    prog_wr_ok_o |-> (prog_wr_req_i && prog_eng_i != 2'h3
                      && in_load[prog_eng_i] && !busy[prog_eng_i])
  ) else $error("program write accepted outside load");

  a_pc_write_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_en_i && addr_i == ADDR_PC0 && !hold_style[0] && !load_entry[0]
     && !exec_done_i[0]) |=> $stable(exec_pc_o[PC_W-1:0])
  ) else $error("counter written outside hold");

  a_step_self_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (clr[0] && !wr_style) |=> style_reg[FIELD_TOP+:2] == STYLE_HOLD
  ) else $error("style did not return to hold");

  a_style_write_take: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_style && chip_en) |=> style_reg[6:0] == $past(wdata_i[6:0])
  ) else $error("style write not taken");

  a_state_write_take: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_state |=> state_reg[5:0] == $past(wdata_i[5:0])
  ) else $error("state write not taken");

  a_pc_write_take: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    pc_wr[0] |=> exec_pc_o[PC_W-1:0] == $past(wdata_i[PC_W-1:0])
  ) else $error("counter write under hold lost");

  a_pc_read_lock: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_en_i && addr_i == ADDR_PC0 && !(chip_en && hold_style[0])) |=> rdata_o == 8'h00
  ) else $error("counter read outside hold");

  a_busy_read_map: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_en_i && addr_i == ADDR_BUSY) |=> rdata_o[ENGINES-1:0] == $past(busy)
  ) else $error("busy flags read wrong");

  a_prog_gate_open: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (prog_wr_req_i && prog_eng_i == 2'h2 && in_load[2] && !busy[2]) |-> prog_wr_ok_o
  ) else $error("program write refused in load");

  a_standby_no_go: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !normal_o |=> exec_go_o == '0
  ) else $error("engine fetched outside normal mode");

  a_rdata_stands: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !rd_en_i |=> $stable(rdata_o)
  ) else $error("read data moved without a read");

  a_load_clear_last: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    load_entry[2] |=> exec_pc_o[3*PC_W-1:2*PC_W] == '0
  ) else $error("load entry left the last counter set");

endmodule

// ==== hdl/engine_run_pkg.sv ====
// constants and types for the engine run control block
package engine_run_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_STYLE = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h01;
  localparam logic [7:0] ADDR_PC0   = 8'h37;
  localparam logic [7:0] ADDR_BUSY  = 8'h3a;

  localparam int         CHIP_EN_BIT = 6;
  localparam int         FIELD_TOP   = 4;
  localparam logic [7:0] STYLE_RST   = 8'h00;
  localparam logic [7:0] STATE_RST   = 8'h00;

  // ************************************************************
  // engine counter and timing
  // ************************************************************
  localparam int         PC_W         = 7;
  localparam logic [6:0] PC_LIMIT_DEF = 7'h5f;
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         STARTUP_NS    = 500;
  localparam int         STARTUP_CYC   = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         CNT_W         = 16;

  typedef enum logic [1:0] {
    STYLE_HOLD = 2'b00,
    STYLE_STEP = 2'b01,
    STYLE_FREE = 2'b10,
    STYLE_ONCE = 2'b11
  } style_e;

  typedef enum logic [1:0] {
    ST_DISABLED = 2'b00,
    ST_LOAD     = 2'b01,
    ST_RUN      = 2'b10,
    ST_HALT     = 2'b11
  } state_e;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_BUSY = 1'b1
  } seq_e;

  // low bit of engine k's two-bit field
  function automatic int field_lo(input int k);
    return FIELD_TOP - 2 * k;
  endfunction

endpackage

// ==== hdl/engine_seq.sv ====
// instruction flow sequencer for one execution engine
`timescale 1ns/1ps
module engine_seq
  import engine_run_pkg::*;
#(
  parameter logic [PC_W-1:0] PC_LIMIT = PC_LIMIT_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control side
  engine_if.eng    e
);

  seq_e            seq;
  seq_e            next_seq;
  style_e          held;
  style_e          next_held;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic            go;
  logic            next_go;
  logic            abort;
  logic            next_abort;
  logic            clr;
  logic            next_clr;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_seq   = seq;
    next_held  = held;
    next_pc    = pc;
    next_go    = 1'b0;
    next_abort = 1'b0;
    next_clr   = 1'b0;
    case (seq)
      SEQ_IDLE: begin
        // fetch only in run
        // a pending self-clear still shows the old style for a cycle
        if (e.run_ok && e.state == ST_RUN && e.style != STYLE_HOLD && !clr) begin
          next_seq  = SEQ_BUSY;
          next_go   = 1'b1;
          next_held = e.style;
        end
      end
      SEQ_BUSY: begin
        if (e.state == ST_HALT) begin
          next_seq   = SEQ_IDLE;
          next_abort = 1'b1;
        end else if (e.done) begin
          next_seq = SEQ_IDLE;
          if (held == STYLE_STEP || held == STYLE_FREE) begin
            next_pc = (pc == PC_LIMIT) ? '0 : pc + 1'b1;
          end
          // free run keeps its style, so it reissues
          next_clr = (held == STYLE_STEP || held == STYLE_ONCE);
        end
      end
      default: next_seq = SEQ_IDLE;
    endcase
    if (e.load_entry) begin
      next_pc = '0;
    end else if (e.pc_wr) begin
      next_pc = e.pc_wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq   <= SEQ_IDLE;
      held  <= STYLE_HOLD;
      pc    <= '0;
      go    <= 1'b0;
      abort <= 1'b0;
      clr   <= 1'b0;
    end else begin
      seq   <= next_seq;
      held  <= next_held;
      pc    <= next_pc;
      go    <= next_go;
      abort <= next_abort;
      clr   <= next_clr;
    end
  end

  assign e.go    = go;
  assign e.abort = abort;
  assign e.busy  = (seq == SEQ_BUSY);
  assign e.clr   = clr;
  assign e.pc    = pc;

  // ************************************************************
  // checks
  // ************************************************************
  a_halt_abort_now: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (seq == SEQ_BUSY && e.state == ST_HALT) |=> (abort && seq == SEQ_IDLE)
  ) else $error("halt did not abort the engine");

  a_once_pc_keep: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (seq == SEQ_BUSY && held == STYLE_ONCE && e.done && e.state != ST_HALT
     && !e.load_entry && !e.pc_wr) |=> ($stable(pc) && clr)
  ) else $error("execute once moved the counter or kept its style");

  a_step_pc_next: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (seq == SEQ_BUSY && held == STYLE_STEP && e.done && e.state != ST_HALT
     && !e.load_entry && !e.pc_wr && pc != PC_LIMIT)
    |=> (pc == $past(pc) + 1'b1) && clr
  ) else $error("step did not advance the counter");

  a_pc_wrap_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (seq == SEQ_BUSY && held == STYLE_FREE && e.done && e.state != ST_HALT
     && !e.pc_wr && pc == PC_LIMIT) |=> pc == '0
  ) else $error("counter did not wrap at its limit");

  a_no_fetch_idle: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (e.state != ST_RUN || e.style == STYLE_HOLD || !e.run_ok) |=> !go
  ) else $error("fetch outside run or under hold");

endmodule
